// ==== hw/scchp_top.sv ====
// Purpose: security context cache and header processing front end
// Assumes: requests, fetch answers and done reports come from logic on clk_i
// Notes: one request in flight; registers over classic Wishbone
//
// The register addresses and register access over Wishbone are this design's own decisions.
`include "scchp_defines.svh"
module scchp_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [15:0] req_scid_i,
    input wire logic [31:0] req_ptr_i,
    input wire scchp_pkg::scchp_proto_type req_proto_i,
    input wire logic req_data_mode_i,
    input wire logic req_label_valid_i,
    input wire logic [31:0] req_label_i,
    input wire logic req_verify_i,
    input wire logic [31:0] req_seq_i,
    input wire logic [31:0] req_tag_pkt_i,
    input wire logic [31:0] req_tag_calc_i,
    output logic fetch_req_o,
    output logic [31:0] fetch_addr_o,
    input wire logic fetch_done_i,
    input wire logic fetch_replay_en_i,
    input wire logic done_valid_i,
    input wire logic [5:0] done_entry_i,
    output logic out_valid_o,
    output logic out_drop_o,
    output logic [31:0] out_label_o,
    output logic [7:0] out_err_o,
    output logic out_tag_insert_o,
    output logic [31:0] out_tag_o,
    output logic [5:0] out_entry_o
);
    import scchp_pkg::*;
    localparam int ENT = `SCCHP_ENTRIES;
    localparam int TW = `SCCHP_TAG_W;

    scchp_state_type state_reg, state_next;
    logic [15:0] scid_reg;
    logic [31:0] ptr_reg, label_reg, seq_reg, tpkt_reg, tcalc_reg;
    scchp_proto_type proto_reg;
    logic dm_reg, lv_reg, verify_reg;
    logic [ENT-1:0] valid_reg, first_reg, replay_reg, seen_reg, active_reg;
    logic [TW-1:0] tag_mem [ENT];
    logic [1:0] age_mem [ENT];
    logic [31:0] seq_mem [ENT];
    logic [1:0] fill_way_reg;
    logic [5:0] cur_reg;
    logic fetch_reg;
    logic [1:0] ctrl_reg;
    logic [15:0] hit_cnt_reg, miss_cnt_reg;
    logic [15:0] ev_id_reg;
    logic ev_ok_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic ov_reg, od_reg, oi_reg;
    logic [31:0] ol_reg, ot_reg;
    logic [7:0] oe_reg;
    logic [5:0] oent_reg;

    // set select and per-way views
    wire [3:0] set_sel = scid_reg[`SCCHP_SET_W-1:0];
    wire [TW-1:0] key = scid_reg[TW-1:0];
    logic [3:0] s_valid, s_first, s_active;
    logic [4*TW-1:0] s_tags;
    logic [7:0] s_ages;
    logic hit, empty, victim;
    logic [1:0] hit_way, empty_way, victim_way, touch_way;
    logic [2:0] first_cnt;
    logic [1:0] age_next [4];
    wire [3:0] ev_set = wb_dat_i[3:0];
    logic [3:0] ev_match;

    for (genvar w = 0; w < 4; w++) begin : g_way
        assign s_valid[w] = valid_reg[{set_sel, 2'(w)}];
        assign s_first[w] = first_reg[{set_sel, 2'(w)}];
        assign s_active[w] = active_reg[{set_sel, 2'(w)}];
        assign s_tags[w*TW +: TW] = tag_mem[{set_sel, 2'(w)}];
        assign s_ages[w*2 +: 2] = age_mem[{set_sel, 2'(w)}];
        // most recent goes to zero, younger ones age by one
        assign age_next[w] = (2'(w) == touch_way) ? 2'h0 :
            (s_ages[w*2 +: 2] < s_ages[touch_way*2 +: 2]) ? s_ages[w*2 +: 2] + 2'h1 : s_ages[w*2 +: 2];
        assign ev_match[w] = valid_reg[{ev_set, 2'(w)}] && !active_reg[{ev_set, 2'(w)}]
            && tag_mem[{ev_set, 2'(w)}] == wb_dat_i[TW-1:0];
    end

    scchp_way_select #(.WAYS(4), .TAG_W(TW)) u_sel (
        .key_i(key),
        .valid_i(s_valid),
        .first_i(s_first),
        .active_i(s_active),
        .tags_i(s_tags),
        .ages_i(s_ages),
        .hit_o(hit),
        .hit_way_o(hit_way),
        .empty_o(empty),
        .empty_way_o(empty_way),
        .victim_o(victim),
        .victim_way_o(victim_way),
        .first_cnt_o(first_cnt)
    );

    function automatic logic [1:0] enc4(input logic [3:0] m);
        enc4 = m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
    endfunction

    // header processors: ipsec on index 0, third on index 1
    logic [31:0] hp_label [2];
    logic [1:0] hp_drop, hp_ins;
    logic [7:0] hp_err [2];
    for (genvar p = 0; p < 2; p++) begin : g_hp
        scchp_header_proc u_hp (
            .fw_loaded_i(ctrl_reg[p]),
            .proto_i(proto_reg),
            .scid_i(scid_reg),
            .verify_i(verify_reg),
            .replay_en_i(replay_reg[cur_reg]),
            .seq_seen_i(seen_reg[cur_reg]),
            .seq_i(seq_reg),
            .last_seq_i(seq_mem[cur_reg]),
            .tag_pkt_i(tpkt_reg),
            .tag_calc_i(tcalc_reg),
            .label_o(hp_label[p]),
            .drop_o(hp_drop[p]),
            .err_o(hp_err[p]),
            .insert_o(hp_ins[p])
        );
    end

    wire take = req_valid_i && req_ready_o;
    wire is_look = state_reg == ST_LOOK;
    wire is_proc = state_reg == ST_PROC;
    wire look_hit = is_look && hit;
    wire look_miss = is_look && !hit && (empty || victim);
    wire fill_en = state_reg == ST_FETCH && fetch_done_i;
    wire touch_en = look_hit || fill_en;
    assign touch_way = look_hit ? hit_way : fill_way_reg;
    wire [5:0] fill_idx = {set_sel, fill_way_reg};
    wire fill_first = scid_reg[`SCCHP_TIER_BIT] && first_cnt < `SCCHP_TIER_MAX;
    wire hp_sel = proto_reg == PROTO_SRTP;
    wire dm_drop = dm_reg && !lv_reg;
    wire drop_next = dm_reg ? dm_drop : hp_drop[hp_sel];
    wire [7:0] err_next = dm_reg ? (dm_drop ? `SCCHP_ERR_NOLABEL : `SCCHP_ERR_NONE) : hp_err[hp_sel];
    wire [31:0] label_next = dm_reg ? label_reg : hp_label[hp_sel];
    wire ins_next = !dm_reg && hp_ins[hp_sel];
    wire commit = is_proc && !drop_next;
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire bus_end = wb_cyc_i && wb_stb_i && ack_reg;
    wire wr = bus_end && wb_we_i && wb_sel_i[0];
    wire ev_wr = wr && wb_adr_i == `SCCHP_A_EVICT;
    wire ev_hit = ev_wr && |ev_match;
    wire [5:0] ev_idx = {ev_set, enc4(ev_match)};
    wire [31:0] rdat_next = wb_adr_i == `SCCHP_A_CTRL ? {30'h0, ctrl_reg} :
        wb_adr_i == `SCCHP_A_STAT ? {miss_cnt_reg, hit_cnt_reg} :
        wb_adr_i == `SCCHP_A_EVICT ? {ev_ok_reg, 15'h0, ev_id_reg} : 32'h0;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (take) state_next = ST_LOOK;
            ST_LOOK: begin
                if (hit) state_next = ST_PROC;
                else if (empty || victim) state_next = ST_FETCH;
            end
            ST_FETCH: if (fetch_done_i) state_next = ST_PROC;
            ST_PROC: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            fetch_reg <= 1'b0;
            hit_cnt_reg <= 16'h0;
            miss_cnt_reg <= 16'h0;
        end else begin
            state_reg <= state_next;
            fetch_reg <= look_miss || (fetch_reg && !fetch_done_i);
            hit_cnt_reg <= hit_cnt_reg + 16'(look_hit);
            miss_cnt_reg <= miss_cnt_reg + 16'(look_miss);
        end
    end

    always_ff @(posedge clk_i) begin
        if (take) begin
            scid_reg <= req_scid_i;
            ptr_reg <= req_ptr_i;
            proto_reg <= req_proto_i;
            dm_reg <= req_data_mode_i;
            lv_reg <= req_label_valid_i;
            label_reg <= req_label_i;
            verify_reg <= req_verify_i;
            seq_reg <= req_seq_i;
            tpkt_reg <= req_tag_pkt_i;
            tcalc_reg <= req_tag_calc_i;
        end
        if (look_miss) fill_way_reg <= empty ? empty_way : victim_way;
        if (look_hit) cur_reg <= {set_sel, hit_way};
        if (fill_en) cur_reg <= fill_idx;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_reg <= '0;
            first_reg <= '0;
            active_reg <= '0;
            seen_reg <= '0;
            replay_reg <= '0;
            for (int i = 0; i < ENT; i++) age_mem[i] <= 2'(i);
        end else begin
            if (done_valid_i) active_reg[done_entry_i] <= 1'b0;
            if (ev_hit) begin
                valid_reg[ev_idx] <= 1'b0;
                first_reg[ev_idx] <= 1'b0;
            end
            if (fill_en) begin
                valid_reg[fill_idx] <= 1'b1;
                tag_mem[fill_idx] <= key;
                first_reg[fill_idx] <= fill_first;
                replay_reg[fill_idx] <= fetch_replay_en_i;
                seen_reg[fill_idx] <= 1'b0;
            end
            if (touch_en) for (int j = 0; j < 4; j++) age_mem[{set_sel, 2'(j)}] <= age_next[j];
            if (commit) active_reg[cur_reg] <= 1'b1;
            if (commit && !dm_reg && replay_reg[cur_reg]) begin
                seq_mem[cur_reg] <= seq_reg;
                seen_reg[cur_reg] <= 1'b1;
            end
        end
    end

    // register slave: ack one cycle after the strobe, writes land on the edge that ends the ack cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
            ctrl_reg <= `SCCHP_CTRL_RST;
            ev_id_reg <= 16'h0;
            ev_ok_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) rdat_reg <= rdat_next;
            if (wr && wb_adr_i == `SCCHP_A_CTRL) ctrl_reg <= wb_dat_i[1:0];
            if (ev_wr) ev_id_reg <= wb_dat_i[15:0];
            if (ev_wr) ev_ok_reg <= |ev_match;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ov_reg <= 1'b0;
            od_reg <= 1'b0;
            oi_reg <= 1'b0;
            ol_reg <= 32'h0;
            ot_reg <= 32'h0;
            oe_reg <= `SCCHP_ERR_NONE;
            oent_reg <= 6'h0;
        end else begin
            ov_reg <= is_proc;
            if (is_proc) begin
                od_reg <= drop_next;
                oi_reg <= ins_next;
                ol_reg <= label_next;
                ot_reg <= tcalc_reg;
                oe_reg <= err_next;
                oent_reg <= cur_reg;
            end
        end
    end

    assign req_ready_o = state_reg[0];
    assign fetch_req_o = fetch_reg;
    assign fetch_addr_o = ptr_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign out_valid_o = ov_reg;
    assign out_drop_o = od_reg;
    assign out_label_o = ol_reg;
    assign out_err_o = oe_reg;
    assign out_tag_insert_o = oi_reg;
    assign out_tag_o = ot_reg;
    assign out_entry_o = oent_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_FILL_SET: assert property (fill_en |=> valid_reg[{scid_reg[3:0], fill_way_reg}])
        else $error("fill landed outside the selected set");
    AST_HIT_NO_FETCH: assert property (look_hit |=> is_proc && !fetch_req_o)
        else $error("hit caused a fetch");
    AST_FETCH_PTR: assert property (fetch_req_o |-> state_reg == ST_FETCH && $stable(fetch_addr_o))
        else $error("fetch address is not the request pointer");
    AST_EMPTY_FIRST: assert property (look_miss && empty |=> fill_way_reg == empty_way)
        else $error("miss did not use first empty way");
    AST_NO_TIER_EVICT: assert property (fill_en && s_valid[fill_way_reg] |-> !s_first[fill_way_reg])
        else $error("first tier entry evicted");
    AST_TIER_LIMIT: assert property (is_look |-> first_cnt != 3'h4)
        else $error("whole set is first tier");
    AST_NOLABEL_DROP: assert property (is_proc && dm_reg && !lv_reg |=> out_valid_o && out_drop_o
        && out_err_o == `SCCHP_ERR_NOLABEL)
        else $error("unlabelled data mode packet not dropped");
    AST_AH_NO_INSERT: assert property (is_proc && proto_reg == PROTO_AH |=> !out_tag_insert_o)
        else $error("tag inserted for AH");
    AST_TAG_FAIL: assert property (is_proc && !dm_reg && verify_reg && tpkt_reg != tcalc_reg
        && ctrl_reg[hp_sel] |=> out_err_o == `SCCHP_ERR_AUTH)
        else $error("tag mismatch not flagged");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    COV_HIT: cover property (look_hit ##1 is_proc ##1 out_valid_o);
    COV_FILL_VICTIM: cover property (look_miss && !empty ##[1:20] fill_en);
    COV_REPLAY_DROP: cover property (is_proc && !dm_reg && drop_next && ctrl_reg[hp_sel]);
    COV_EVICT: cover property (ev_hit);
endmodule

// ==== hw/scchp_defines.svh ====
// Purpose: constants of the context cache and header processing front end
// Assumes: included by every design module
// Notes: register offsets are byte addresses
`ifndef SCCHP_DEFINES_SVH
`define SCCHP_DEFINES_SVH
`define SCCHP_WAYS 4
`define SCCHP_SETS 16
`define SCCHP_ENTRIES 64
`define SCCHP_ID_W 16
`define SCCHP_TAG_W 15
`define SCCHP_TIER_BIT 15
`define SCCHP_SET_W 4
`define SCCHP_PTR_W 32
`define SCCHP_TIER_MAX 3'h3
`define SCCHP_A_CTRL 8'h00
`define SCCHP_A_STAT 8'h04
`define SCCHP_A_EVICT 8'h08
`define SCCHP_CTRL_RST 2'h0
`define SCCHP_ERR_NONE 8'h00
`define SCCHP_ERR_AUTH 8'h01
`define SCCHP_ERR_NOLABEL 8'h02
`define SCCHP_ERR_NOFW 8'h03
`endif

// ==== hw/scchp_pkg.sv ====
// Purpose: shared types
// Assumes: nothing
// Notes: states are one-hot
package scchp_pkg;
    typedef enum logic [1:0] {PROTO_AH = 2'h0, PROTO_ESP = 2'h1, PROTO_SRTP = 2'h2} scchp_proto_type;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOOK = 4'h2,
        ST_FETCH = 4'h4,
        ST_PROC = 4'h8
    } scchp_state_type;
endpackage

// ==== hw/scchp_way_select.sv ====
// Purpose: match, empty slot and victim search in one cache set
// Assumes: ages of a set form a permutation
// Notes: purely combinational
`include "scchp_defines.svh"
module scchp_way_select #(
    parameter int WAYS = `SCCHP_WAYS,
    parameter int TAG_W = `SCCHP_TAG_W
) (
    input wire logic [TAG_W-1:0] key_i,
    input wire logic [WAYS-1:0] valid_i,
    input wire logic [WAYS-1:0] first_i,
    input wire logic [WAYS-1:0] active_i,
    input wire logic [WAYS*TAG_W-1:0] tags_i,
    input wire logic [WAYS*2-1:0] ages_i,
    output logic hit_o,
    output logic [1:0] hit_way_o,
    output logic empty_o,
    output logic [1:0] empty_way_o,
    output logic victim_o,
    output logic [1:0] victim_way_o,
    output logic [2:0] first_cnt_o
);
    logic [1:0] best;
    if (WAYS != 4) begin : g_bad
        $error("only four ways are supported");
    end
    always_comb begin
        hit_o = 1'b0;
        hit_way_o = 2'h0;
        empty_o = 1'b0;
        empty_way_o = 2'h0;
        victim_o = 1'b0;
        victim_way_o = 2'h0;
        first_cnt_o = 3'h0;
        best = 2'h0;
        for (int i = WAYS - 1; i >= 0; i--) begin
            if (!valid_i[i]) begin
                empty_o = 1'b1;
                empty_way_o = 2'(i);
            end
        end
        for (int i = 0; i < WAYS; i++) begin
            if (valid_i[i] && tags_i[i*TAG_W +: TAG_W] == key_i) begin
                hit_o = 1'b1;
                hit_way_o = 2'(i);
            end
            if (valid_i[i] && first_i[i]) begin
                first_cnt_o = first_cnt_o + 3'h1;
            end
            // oldest way that is neither busy nor first tier
            if (valid_i[i] && !first_i[i] && !active_i[i] && (!victim_o || ages_i[i*2 +: 2] > best)) begin
                victim_o = 1'b1;
                victim_way_o = 2'(i);
                best = ages_i[i*2 +: 2];
            end
        end
    end
endmodule

// ==== hw/scchp_header_proc.sv ====
// Purpose: one header processor: label, tag check, tag insert, replay drop
// Assumes: firmware image presence given by fw_loaded_i
// Notes: combinational; same hardware for every instance
`include "scchp_defines.svh"
module scchp_header_proc (
    input wire logic fw_loaded_i,
    input wire scchp_pkg::scchp_proto_type proto_i,
    input wire logic [15:0] scid_i,
    input wire logic verify_i,
    input wire logic replay_en_i,
    input wire logic seq_seen_i,
    input wire logic [31:0] seq_i,
    input wire logic [31:0] last_seq_i,
    input wire logic [31:0] tag_pkt_i,
    input wire logic [31:0] tag_calc_i,
    output logic [31:0] label_o,
    output logic drop_o,
    output logic [7:0] err_o,
    output logic insert_o
);
    import scchp_pkg::*;
    wire dup = replay_en_i && seq_seen_i && seq_i <= last_seq_i;
    wire ins = proto_i != PROTO_AH;
    wire bad_tag = verify_i && tag_pkt_i != tag_calc_i;
    assign label_o = {scid_i, 12'h000, ins, verify_i, proto_i};
    assign drop_o = !fw_loaded_i || dup;
    assign insert_o = fw_loaded_i && ins && !dup;
    assign err_o = !fw_loaded_i ? `SCCHP_ERR_NOFW : bad_tag ? `SCCHP_ERR_AUTH : `SCCHP_ERR_NONE;
endmodule

// ==== sim/scchp_host_model.sv ====
// Purpose: host memory side answering context fetches
// Assumes: one fetch at a time, fetch_req_i level until done
// Notes: delay_i sets answer latency in cycles
module scchp_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_addr_i,
    input wire logic [3:0] delay_i,
    input wire logic replay_i,
    output logic fetch_done_o,
    output logic replay_en_o,
    output logic [31:0] last_addr_o,
    output logic [7:0] count_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        fetch_done_o = 1'b0;
        replay_en_o = 1'b0;
        last_addr_o = 32'h0;
        count_o = 8'h0;
        forever begin
            @(posedge clk_i);
            if (fetch_req_i === 1'b1 && rst_i === 1'b0) begin
                repeat (delay_i) @(posedge clk_i);
                fetch_done_o <= 1'b1;
                replay_en_o <= replay_i;
                last_addr_o <= fetch_addr_i;
                count_o <= count_o + 8'h1;
                @(posedge clk_i);
                fetch_done_o <= 1'b0;
                replay_en_o <= ~replay_i;
            end
        end
    end
endmodule

// ==== sim/security_context_cache_and_header_proc_bench.sv ====
// Purpose: self-checking bench of the context cache front end
// Assumes: host fetch model answers misses
// Notes: every scenario but the reset ready and unmapped read checks is its own task
`include "scchp_defines.svh"
module security_context_cache_and_header_proc_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import scchp_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, req_valid = 1'b0, req_ready;
    logic [7:0] wb_adr = 8'h0;
    logic [3:0] wb_sel = 4'h0, delay = 4'h1;
    logic [31:0] wb_dat = 32'h0, wb_rd, req_ptr = 32'h0, req_label = 32'h0, req_seq = 32'h0;
    logic [31:0] req_tag_pkt = 32'h0, req_tag_calc = 32'h0, fetch_addr, out_label, out_tag, last_addr, rd;
    logic [15:0] req_scid = 16'h0;
    scchp_proto_type req_proto = PROTO_AH;
    logic req_data_mode = 1'b0, req_label_valid = 1'b0, req_verify = 1'b0, fetch_req, fetch_done, replay_en;
    logic done_valid = 1'b0, replay_sel = 1'b0, out_valid, out_drop, out_tag_insert, fetched;
    logic [5:0] done_entry = 6'h0, out_entry;
    logic [7:0] out_err, fetch_cnt;
    int mismatches = 0, total_checks = 0, lat;
    scchp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_scid_i(req_scid), .req_ptr_i(req_ptr),
        .req_proto_i(req_proto), .req_data_mode_i(req_data_mode), .req_label_valid_i(req_label_valid),
        .req_label_i(req_label), .req_verify_i(req_verify), .req_seq_i(req_seq), .req_tag_pkt_i(req_tag_pkt),
        .req_tag_calc_i(req_tag_calc), .fetch_req_o(fetch_req), .fetch_addr_o(fetch_addr),
        .fetch_done_i(fetch_done), .fetch_replay_en_i(replay_en), .done_valid_i(done_valid),
        .done_entry_i(done_entry), .out_valid_o(out_valid), .out_drop_o(out_drop), .out_label_o(out_label),
        .out_err_o(out_err), .out_tag_insert_o(out_tag_insert), .out_tag_o(out_tag), .out_entry_o(out_entry));
    scchp_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr),
        .delay_i(delay), .replay_i(replay_sel), .fetch_done_o(fetch_done), .replay_en_o(replay_en),
        .last_addr_o(last_addr), .count_o(fetch_cnt));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_sel <= 4'hf; wb_dat <= dat;
        do begin @(posedge clk_i); n++; end while (wb_ack !== 1'b1 && n < 50);
        chk(32'(wb_ack), 32'h1, "no bus ack");
        rd = wb_rd;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic send(input logic [15:0] id, input scchp_proto_type pr, input logic dm, input logic lv,
        input logic ver, input logic [31:0] seq, input logic [31:0] tp, input logic [31:0] tc);
        int n;
        logic [7:0] c0;
        n = 0;
        c0 = fetch_cnt;
        req_scid <= id; req_ptr <= {10'h0, id, 6'h00}; req_proto <= pr; req_data_mode <= dm;
        req_label_valid <= lv; req_label <= {16'h5a5a, id}; req_verify <= ver; req_seq <= seq;
        req_tag_pkt <= tp; req_tag_calc <= tc; req_valid <= 1'b1;
        do begin @(posedge clk_i); n++; end while (req_ready !== 1'b1 && n < 100);
        req_valid <= 1'b0;
        lat = 0;
        do begin @(posedge clk_i); lat++; end while (out_valid !== 1'b1 && lat < 200);
        fetched = (fetch_cnt != c0);
        chk(32'(out_valid), 32'h1, "no result");
        if (out_drop !== 1'b1) begin
            done_valid <= 1'b1; done_entry <= out_entry;
            @(posedge clk_i);
            done_valid <= 1'b0;
        end
    endtask
    task automatic t_miss_hit;
        send(16'h0001, PROTO_ESP, 1'b0, 1'b0, 1'b1, 32'h1, 32'h77, 32'h77);
        chk(32'(fetched), 32'h1, "miss no fetch");
        chk(last_addr, 32'h0000_0040, "fetch pointer");
        chk(32'(out_entry), 32'h04, "fill way");
        chk(out_label, 32'h0001_000d, "esp label");
        chk(32'(out_err), 32'h0, "esp err");
        send(16'h0001, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'h2, 32'h0, 32'h0);
        chk(32'(fetched), 32'h0, "hit fetched");
        chk(lat, 32'h3, "hit latency");
        send(16'h0011, PROTO_AH, 1'b0, 1'b0, 1'b0, 32'h1, 32'h0, 32'h0);
        chk(32'(out_entry), 32'h05, "second way");
        wb(1'b0, `SCCHP_A_STAT, 32'h0);
        chk(rd, 32'h0002_0001, "hit miss counts");
    endtask
    task automatic t_lru;
        for (int i = 0; i < 4; i++) send(16'h0002 + 16'(i * 16), PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'h1, 32'h0, 32'h0);
        chk(32'(out_entry), 32'h0b, "fourth way");
        send(16'h0002, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'h2, 32'h0, 32'h0);
        send(16'h0042, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'h1, 32'h0, 32'h0);
        chk(32'(out_entry), 32'h09, "lru victim");
    endtask
    task automatic t_tier;
        for (int i = 0; i < 4; i++) send(16'h8003 + 16'(i * 16), PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'h1, 32'h0, 32'h0);
        send(16'h0043, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'h1, 32'h0, 32'h0);
        chk(32'(out_entry), 32'h0f, "demoted victim");
        wb(1'b1, `SCCHP_A_EVICT, 32'h0000_8003);
        wb(1'b0, `SCCHP_A_EVICT, 32'h0);
        chk(rd, 32'h8000_8003, "evict status");
        send(16'h0053, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'h1, 32'h0, 32'h0);
        chk(32'(out_entry), 32'h0c, "freed way");
    endtask
    task automatic t_proto;
        scchp_proto_type pr;
        logic ins;
        for (int i = 0; i < 3; i++) begin
            pr = scchp_proto_type'(i[1:0]);
            ins = (pr != PROTO_AH);
            send(16'h0004 + 16'(i * 16), pr, 1'b0, 1'b0, 1'b1, 32'h1, 32'h1111, 32'h2222);
            chk(32'(out_drop), 32'h0, "auth fail dropped");
            chk(32'(out_err), 32'(`SCCHP_ERR_AUTH), "auth code");
            chk(32'(out_tag_insert), 32'(ins), "insert flag");
            chk(out_label, {16'h0004 + 16'(i * 16), 12'h0, ins, 1'b1, pr}, "label");
            chk(out_tag, 32'h2222, "tag out");
        end
    endtask
    task automatic t_data_mode;
        send(16'h0004, PROTO_ESP, 1'b1, 1'b0, 1'b0, 32'h2, 32'h0, 32'h0);
        chk(32'(out_drop), 32'h1, "no label kept");
        chk(32'(out_err), 32'(`SCCHP_ERR_NOLABEL), "no label code");
        send(16'h0004, PROTO_ESP, 1'b1, 1'b1, 1'b0, 32'h3, 32'h0, 32'h0);
        chk(out_label, 32'h5a5a_0004, "given label");
    endtask
    task automatic t_replay;
        delay <= 4'h6;
        replay_sel <= 1'b1;
        send(16'h0005, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'ha, 32'h0, 32'h0);
        send(16'h0005, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'ha, 32'h0, 32'h0);
        chk(32'(out_drop), 32'h1, "duplicate kept");
        send(16'h0005, PROTO_ESP, 1'b0, 1'b0, 1'b0, 32'hb, 32'h0, 32'h0);
        chk(32'(out_drop), 32'h0, "fresh dropped");
        replay_sel <= 1'b0;
        send(16'h0015, PROTO_AH, 1'b0, 1'b0, 1'b0, 32'ha, 32'h0, 32'h0);
        send(16'h0015, PROTO_AH, 1'b0, 1'b0, 1'b0, 32'ha, 32'h0, 32'h0);
        chk(32'(out_drop), 32'h0, "check not off");
        delay <= 4'h1;
    endtask
    task automatic t_fw;
        wb(1'b1, `SCCHP_A_CTRL, 32'h1);
        send(16'h0024, PROTO_SRTP, 1'b0, 1'b0, 1'b0, 32'h5, 32'h0, 32'h0);
        chk({23'h0, out_drop, out_err}, 32'h103, "third image missing");
        wb(1'b1, `SCCHP_A_CTRL, 32'h2);
        wb(1'b0, `SCCHP_A_CTRL, 32'h0);
        chk(rd, 32'h2, "ctrl readback");
        send(16'h0004, PROTO_AH, 1'b0, 1'b0, 1'b0, 32'h6, 32'h0, 32'h0);
        chk({23'h0, out_drop, out_err}, 32'h103, "ipsec image missing");
        wb(1'b1, `SCCHP_A_CTRL, 32'h3);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        @(posedge clk_i);
        chk(32'(req_ready), 32'h1, "ready after reset");
        wb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wb(1'b1, `SCCHP_A_CTRL, 32'h3);
        t_miss_hit();
        t_lru();
        t_tier();
        t_proto();
        t_data_mode();
        t_replay();
        t_fw();
        give_verdict();
    end
endmodule
